// [verilog/pss_sequencer.v]
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_sequencer (
  input wire clk_in,
  input wire rst_in,
  output reg mem_req_out,
  output reg [`PSS_ADDR_W-1:0] mem_addr_out,
  input wire mem_ack_in,
  input wire [`PSS_WORD_W-1:0] mem_data_in,
  input wire step_wide_in,
  input wire op_long_in,
  output wire issue_valid_out,
  input wire issue_ready_in,
  output reg issue_wide_out,
  output reg issue_lower_out,
  output reg [`PSS_WORD_W-1:0] issue_word_out,
  output wire [8:0] opcode_out,
  output wire [2:0] index_code_out,
  output reg [`PSS_ADDR_W-1:0] exec_addr_out,
  input wire done_in,
  input wire skip_lower_in,
  input wire jump_in,
  input wire [`PSS_ADDR_W-1:0] jump_addr_in,
  output wire [`PSS_ADDR_W-1:0] pc_out
);
  ////////////////////////////////////////////////////////////////
  localparam [1:0] ST_FETCH = 2'h0;
  localparam [1:0] ST_UPPER = 2'h1;
  localparam [1:0] ST_LOWER = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`PSS_ADDR_W-1:0] pc_r;
  reg [`PSS_ADDR_W-1:0] pc_nxt;
  reg [`PSS_WORD_W-1:0] program_step_holding_register_r;
  reg wide_r;
  reg issued_r;
  reg issued_nxt;
  reg lower_r;
  reg lower_nxt;
  wire [`PSS_HALF_W-1:0] upper_half;
  wire [`PSS_HALF_W-1:0] lower_half;
  wire [`PSS_HALF_W-1:0] sel_half;
  ////////////////////////////////////////////////////////////////
  assign upper_half = program_step_holding_register_r[`PSS_WORD_W-1:`PSS_UPPER_LSB];
  assign lower_half = program_step_holding_register_r[`PSS_HALF_W-1:0];
  assign sel_half = lower_r ? lower_half : upper_half;
  assign pc_out = pc_r;
  assign issue_valid_out = (state_r == ST_UPPER || state_r == ST_LOWER) && !issued_r;
  pss_decode u_dec (
    .instr_in(sel_half),
    .op_long_in(op_long_in),
    .opcode_out(opcode_out),
    .index_code_out(index_code_out),
    .exec_addr_out()
  );
  ////////////////////////////////////////////////////////////////
  always @* begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    issued_nxt = issued_r;
    lower_nxt = lower_r;
    case (state_r)
      ST_FETCH: begin
        if (mem_ack_in) begin
          state_nxt = ST_UPPER;
          issued_nxt = 1'b0;
          lower_nxt = 1'b0;
        end
      end
      ST_UPPER: begin
        if (issue_valid_out && issue_ready_in) begin
          issued_nxt = 1'b1;
        end
        if (issued_r && done_in) begin
          issued_nxt = 1'b0;
          if (jump_in) begin
            pc_nxt = jump_addr_in;
            state_nxt = ST_FETCH;
          end else if (wide_r || skip_lower_in) begin
            pc_nxt = pc_r + `PSS_ADDR_ONE;
            state_nxt = ST_FETCH;
          end else begin
            lower_nxt = 1'b1;
            state_nxt = ST_LOWER;
          end
        end
      end
      ST_LOWER: begin
        if (issue_valid_out && issue_ready_in) begin
          issued_nxt = 1'b1;
        end
        if (issued_r && done_in) begin
          issued_nxt = 1'b0;
          lower_nxt = 1'b0;
          state_nxt = ST_FETCH;
          pc_nxt = jump_in ? jump_addr_in : pc_r + `PSS_ADDR_ONE;
        end
      end
      default: begin
        state_nxt = ST_FETCH;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_FETCH;
      pc_r <= `PSS_RESET_ADDR;
      issued_r <= 1'b0;
      lower_r <= 1'b0;
      wide_r <= 1'b0;
      program_step_holding_register_r <= {`PSS_WORD_W{1'b0}};
      mem_req_out <= 1'b0;
      mem_addr_out <= `PSS_RESET_ADDR;
      issue_wide_out <= 1'b0;
      issue_lower_out <= 1'b0;
      issue_word_out <= {`PSS_WORD_W{1'b0}};
      exec_addr_out <= {`PSS_ADDR_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      issued_r <= issued_nxt;
      lower_r <= lower_nxt;
      mem_req_out <= (state_nxt == ST_FETCH) && !(state_r == ST_FETCH && mem_ack_in);
      mem_addr_out <= pc_nxt;
      if (state_r == ST_FETCH && mem_ack_in) begin
        program_step_holding_register_r <= mem_data_in;
        wide_r <= step_wide_in;
      end
      issue_wide_out <= (state_r == ST_FETCH && mem_ack_in) ? step_wide_in : wide_r;
      issue_lower_out <= lower_nxt;
      if (state_r == ST_FETCH && mem_ack_in) begin
        issue_word_out <= mem_data_in;
        exec_addr_out <= mem_data_in[`PSS_UPPER_LSB+`PSS_ADDR_MSB:`PSS_UPPER_LSB];
      end else if (lower_nxt && !lower_r) begin
        issue_word_out <= program_step_holding_register_r;
        exec_addr_out <= program_step_holding_register_r[`PSS_ADDR_MSB:0];
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/pss_map.vh]
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
`define PSS_ADDR_W 15
`define PSS_WORD_W 48
`define PSS_HALF_W 24
`define PSS_UPPER_LSB 24
`define PSS_ADDR_MSB 14
`define PSS_OP6_MSB 23
`define PSS_OP6_LSB 18
`define PSS_OP9_MSB 23
`define PSS_OP9_LSB 15
`define PSS_IDX_MSB 17
`define PSS_IDX_LSB 15
`define PSS_RESET_ADDR 15'h0000
`define PSS_ADDR_ONE 15'h0001
`endif

// [verilog/pss_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.vh"
module pss_decode (
  input wire [`PSS_HALF_W-1:0] instr_in,
  input wire op_long_in,
  output wire [8:0] opcode_out,
  output wire [2:0] index_code_out,
  output wire [`PSS_ADDR_W-1:0] exec_addr_out
);
  // 6-bit code zero-extended, or the 9-bit code
  assign opcode_out = op_long_in ? instr_in[`PSS_OP9_MSB:`PSS_OP9_LSB] :
    {3'h0, instr_in[`PSS_OP6_MSB:`PSS_OP6_LSB]};
  assign index_code_out = instr_in[`PSS_IDX_MSB:`PSS_IDX_LSB];
  assign exec_addr_out = instr_in[`PSS_ADDR_MSB:0];
endmodule
`default_nettype wire

// [tb/pss_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pss_props (
  input wire clk_in, rst_in, mem_req_out, mem_ack_in, op_long_in, issue_valid_out,
  input wire issue_lower_out, issue_wide_out, done_in, skip_lower_in, jump_in,
  input wire [47:0] mem_data_in, issue_word_out,
  input wire [14:0] exec_addr_out, pc_out, jump_addr_in,
  input wire [8:0] opcode_out,
  input wire [2:0] index_code_out
);
  wire tk = mem_req_out & mem_ack_in;
  wire dn = done_in & ~issue_valid_out & ~mem_req_out;
  wire [23:0] h = issue_lower_out ? issue_word_out[23:0] : issue_word_out[47:24];
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_WORD: assert property (tk |=> issue_valid_out && issue_word_out == $past(mem_data_in))
    else $error("step");
  AST_UP: assert property (tk |=> !issue_lower_out && exec_addr_out == $past(mem_data_in[38:24]))
    else $error("upper");
  AST_LOW: assert property (issue_lower_out |-> exec_addr_out == issue_word_out[14:0])
    else $error("lower");
  AST_IDX: assert property (issue_valid_out |-> index_code_out == h[17:15])
    else $error("index");
  AST_OP: assert property (issue_valid_out && op_long_in |-> opcode_out == h[23:15])
    else $error("opcode");
  AST_OP6: assert property (issue_valid_out && !op_long_in |-> opcode_out == {3'h0, h[23:18]})
    else $error("short opcode");
  AST_HOLD: assert property (issue_valid_out |=> $stable(issue_word_out))
    else $error("step not held");
  AST_PAIR: assert property (dn && !issue_lower_out && !issue_wide_out && !skip_lower_in && !jump_in
    |=> issue_valid_out && issue_lower_out) else $error("pair");
  AST_SKIP: assert property (dn && skip_lower_in |=> mem_req_out && !issue_valid_out)
    else $error("skip");
  AST_PC: assert property ($rose(mem_req_out) && !$past(rst_in, 2) |-> pc_out ==
    ($past(jump_in) ? $past(jump_addr_in) : $past(pc_out) + 15'h1)) else $error("pc");
endmodule
bind pss_sequencer pss_props i_pss_props (.*);
`default_nettype wire

// [tb/pss_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pss_mem_model (
  input wire clk_in, rst_in, req_in,
  input wire [14:0] addr_in,
  input wire [3:0] lat_in,
  output reg ack_out,
  output reg [47:0] data_out
);
  reg [3:0] cnt_r = 4'h0;
  initial {ack_out, data_out} = 49'h0;
  // data toggles when not acked, so stale values never look valid
  always @(posedge clk_in) begin
    ack_out <= 1'h0;
    data_out <= ~data_out;
    cnt_r <= 4'h0;
    if (!rst_in && req_in && !ack_out) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r >= lat_in) begin
        ack_out <= 1'h1;
        data_out <= {9'h0a5, addr_in, 9'h15a, ~addr_in};
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb_pss_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pss_sequencer;
  reg clk_in = 0, rst_in = 1, rdy = 0, dn = 0, sk = 0, jp = 0, wd = 0, ol = 0;
  reg [14:0] ja = 15'h0;
  reg [3:0] lat = 4'h0;
  wire req, ack, vld, lo;
  wire [14:0] addr, ea, pc;
  wire [47:0] data;
  integer error_cnt = 0, samples_checked = 0, cyc = 0, n;
  always #4 clk_in = ~clk_in;
  pss_mem_model i_pss_mem_model (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .addr_in(addr), .lat_in(lat), .ack_out(ack), .data_out(data));
  pss_sequencer i_pss_sequencer (.clk_in(clk_in), .rst_in(rst_in), .mem_req_out(req),
    .mem_addr_out(addr), .mem_ack_in(ack), .mem_data_in(data), .step_wide_in(wd),
    .op_long_in(ol), .issue_valid_out(vld), .issue_ready_in(rdy), .issue_wide_out(),
    .issue_lower_out(lo), .issue_word_out(), .opcode_out(), .index_code_out(),
    .exec_addr_out(ea), .done_in(dn), .skip_lower_in(sk), .jump_in(jp),
    .jump_addr_in(ja), .pc_out(pc));
  task chk(input [47:0] a, e);
    samples_checked = samples_checked + 1;
    if (a !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_in) if (++cyc == 3000) begin
    error_cnt = error_cnt + 1;
    wrap_up;
  end
  // wait issue, check it, accept it, then finish it with flags
  task ins(input [14:0] e, input l, s, j, input [14:0] a);
    n = 0;
    while (vld !== 1'h1 && n < 40) begin @(posedge clk_in); #1 n = n + 1; end
    chk(ea, e); chk(lo, l);
    rdy = 1; @(posedge clk_in); #1 rdy = 0;
    dn = 1; sk = s; jp = j; ja = a; @(posedge clk_in); #1 {dn, sk, jp} = 3'h0;
  endtask
  task t_pair;
    ins(15'h0000, 1'h0, 1'h0, 1'h0, 15'h0);
    ins(15'h7fff, 1'h1, 1'h0, 1'h0, 15'h0);
    chk(pc, 15'h1);
  endtask
  task t_skip;
    ol = 1;
    ins(15'h0001, 1'h0, 1'h1, 1'h0, 15'h0);
    ins(15'h0002, 1'h0, 1'h0, 1'h0, 15'h0);
    ins(15'h7ffd, 1'h1, 1'h0, 1'h0, 15'h0);
  endtask
  task t_wide_wrap;
    wd = 1;
    ins(15'h0003, 1'h0, 1'h0, 1'h0, 15'h0);
    ins(15'h0004, 1'h0, 1'h0, 1'h1, 15'h7fff);
    chk(pc, 15'h7fff);
    wd = 0; lat = 4'h3;
    ins(15'h7fff, 1'h0, 1'h1, 1'h0, 15'h0);
    chk(pc, 15'h0);
    ins(15'h0000, 1'h0, 1'h0, 1'h0, 15'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_in = 0;
    t_pair;
    t_skip;
    t_wide_wrap;
    wrap_up;
  end
endmodule
`default_nettype wire
